// [design/ssrc_pkg.sv]
package ssrc_pkg;
    // Register byte offsets on APB
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_PROT_CMD = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_CLK_SEL  = 8'h0c;

    // Control register field positions
    localparam int RATE_LSB   = 0;
    localparam int EN_BIT     = 3;
    localparam int PERIOD_LSB = 4;

    // Reset value and legality limits
    localparam logic [1:0] PERIOD_RST = 2'h1;
    localparam logic [1:0] PERIOD_BAD = 2'h3;
    localparam logic [2:0] RATE_MAX   = 3'h5;

    // Strap reset rate codes, one per strap pin pair value
    localparam logic [2:0] STRAP_RATE_0 = 3'h0;
    localparam logic [2:0] STRAP_RATE_1 = 3'h1;
    localparam logic [2:0] STRAP_RATE_2 = 3'h3;
    localparam logic [2:0] STRAP_RATE_3 = 3'h5;

    // Lock time after a control change
    localparam int LOCK_TIME_US  = 20;
    localparam int CLK_MHZ       = 10;
    localparam int LOCK_CYCLES   = LOCK_TIME_US * CLK_MHZ;

    typedef struct packed {
        logic [1:0] period;
        logic       enable;
        logic [2:0] rate;
    } ssrc_ctrl_t;

    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ssrc_apb_req_t;

    typedef struct packed {
        logic        enable;
        logic [2:0]  rate;
        logic [1:0]  period;
    } ssrc_mod_t;
endpackage : ssrc_pkg

// [design/ssrc_lock_timer.sv]
`timescale 1ns/100ps
module ssrc_lock_timer (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Control
    input  wire logic restart,
    output logic      unlocked
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        unl;
    } ssrc_lt_st_t;

    ssrc_lt_st_t st_ff;
    ssrc_lt_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (restart) begin
            nxt_st.cnt = 16'(ssrc_pkg::LOCK_CYCLES);
            nxt_st.unl = 1'b1;
        end else if (st_ff.cnt != 16'h0) begin
            nxt_st.cnt = st_ff.cnt - 16'h1;
            nxt_st.unl = (st_ff.cnt != 16'h1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_ff <= '{cnt: 16'(ssrc_pkg::LOCK_CYCLES), unl: 1'b1};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign unlocked = st_ff.unl;
endmodule : ssrc_lock_timer

// [design/ssrc_top.sv]
// How it works
// - Enable bit low gives a fixed unmodulated clock whatever the rate code.
// - Rate codes 0 to 5 give -0.5 to -5 percent; 6 and 7 prohibited.
// - Core, bus and peripheral clocks all follow the modulated setting.
// - Reads of the control register need no preceding command.
// - Command data is ignored; software uses matching data for both stores.
// - Period field: 00, 01, 10 select ranges; 11 prohibited.
// - Reset loads period 01; enable and rate come from two strap pins.
// - Writes only with oscillator main clock; any change sets unlocked.
`timescale 1ns/100ps
module ssrc_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Strap pins
    input  wire logic        strap_pin_hi,
    input  wire logic        strap_pin_lo,
    // Modulation setting to the synthesizer, lock status and system clock select
    output logic             modulation_enable,
    output logic      [2:0]  rate_code,
    output logic      [1:0]  period_sel,
    output logic             lock_pending,
    output logic             sys_clk_from_synth
);
    typedef struct packed {
        logic [1:0]  strap_s1;
        logic [1:0]  strap_s2;
        logic        strap_done;
        logic        armed;
        logic        clk_sel;
        ssrc_pkg::ssrc_ctrl_t ctrl;
        ssrc_pkg::ssrc_mod_t  mod;
        logic        lock_out;
        logic        sel_out;
        logic        restart;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
    } ssrc_st_t;

    ssrc_st_t st_ff;
    ssrc_st_t nxt_st;
    logic     unlocked;

    function automatic logic legal_ctrl(input logic [31:0] d);
        legal_ctrl = (d[ssrc_pkg::RATE_LSB +: 3] <= ssrc_pkg::RATE_MAX) &&
                     (d[ssrc_pkg::PERIOD_LSB +: 2] != ssrc_pkg::PERIOD_BAD);
    endfunction : legal_ctrl

    function automatic ssrc_pkg::ssrc_ctrl_t strap_ctrl(input logic [1:0] s);
        ssrc_pkg::ssrc_ctrl_t c;
        c.period = ssrc_pkg::PERIOD_RST;
        c.enable = (s != 2'h0);
        unique case (s)
            2'h0: c.rate = ssrc_pkg::STRAP_RATE_0;
            2'h1: c.rate = ssrc_pkg::STRAP_RATE_1;
            2'h2: c.rate = ssrc_pkg::STRAP_RATE_2;
            2'h3: c.rate = ssrc_pkg::STRAP_RATE_3;
        endcase
        strap_ctrl = c;
    endfunction : strap_ctrl

    ssrc_lock_timer u_lock (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .restart  (st_ff.restart),
        .unlocked (unlocked)
    );

    logic setup;
    assign setup = psel && !penable;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.strap_s1 = {strap_pin_hi, strap_pin_lo};
        nxt_st.strap_s2 = st_ff.strap_s1;
        nxt_st.restart  = 1'b0;
        nxt_st.ready    = 1'b0;
        nxt_st.err      = 1'b0;
        if (!st_ff.strap_done) begin
            nxt_st.ctrl       = strap_ctrl(st_ff.strap_s2);
            nxt_st.strap_done = 1'b1;
            nxt_st.restart    = 1'b1;
        end else if (setup) begin
            nxt_st.ready = 1'b1;
            if (pwrite) begin
                unique case (paddr)
                    ssrc_pkg::OFS_PROT_CMD: nxt_st.armed = 1'b1;
                    ssrc_pkg::OFS_CTRL: begin
                        nxt_st.armed = 1'b0;
                        if (st_ff.armed && !st_ff.clk_sel && legal_ctrl(pwdata)) begin
                            nxt_st.ctrl.rate   = pwdata[ssrc_pkg::RATE_LSB +: 3];
                            nxt_st.ctrl.enable = pwdata[ssrc_pkg::EN_BIT];
                            nxt_st.ctrl.period = pwdata[ssrc_pkg::PERIOD_LSB +: 2];
                            nxt_st.restart     = 1'b1;
                        end else begin
                            nxt_st.err = !st_ff.armed;
                        end
                    end
                    ssrc_pkg::OFS_CLK_SEL: begin
                        nxt_st.armed   = 1'b0;
                        nxt_st.clk_sel = pwdata[0];
                    end
                    default: begin
                        nxt_st.armed = 1'b0;
                        nxt_st.err   = (paddr != ssrc_pkg::OFS_STATUS);
                    end
                endcase
                nxt_st.rdata = 32'h0;
            end else begin
                nxt_st.armed = 1'b0;
                unique case (paddr)
                    ssrc_pkg::OFS_CTRL: nxt_st.rdata = {24'h0, 2'h0, st_ff.ctrl.period,
                        st_ff.ctrl.enable, st_ff.ctrl.rate};
                    ssrc_pkg::OFS_PROT_CMD: nxt_st.rdata = 32'h0;
                    ssrc_pkg::OFS_STATUS:   nxt_st.rdata = {31'h0, unlocked};
                    ssrc_pkg::OFS_CLK_SEL:  nxt_st.rdata = {31'h0, st_ff.clk_sel};
                    default: begin
                        nxt_st.rdata = 32'h0;
                        nxt_st.err   = 1'b1;
                    end
                endcase
            end
        end
        // Gate off modulation when disabled
        nxt_st.mod.enable = st_ff.ctrl.enable;
        nxt_st.mod.rate   = st_ff.ctrl.enable ? st_ff.ctrl.rate : 3'h0;
        nxt_st.mod.period = st_ff.ctrl.period;
        nxt_st.lock_out   = unlocked;
        nxt_st.sel_out    = st_ff.clk_sel;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            // Strap synchroniser keeps sampling so capture sees the pins
            st_ff          <= '0;
            st_ff.strap_s1 <= nxt_st.strap_s1;
            st_ff.strap_s2 <= nxt_st.strap_s2;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata             = st_ff.rdata;
    assign pready             = st_ff.ready;
    assign pslverr            = st_ff.err;
    assign modulation_enable  = st_ff.mod.enable;
    assign rate_code          = st_ff.mod.rate;
    assign period_sel         = st_ff.mod.period;
    assign lock_pending       = st_ff.lock_out;
    assign sys_clk_from_synth = st_ff.sel_out;

    a_unarmed_no_write: assert property (@(posedge clk) disable iff (sys_rst)
        (st_ff.strap_done && setup && pwrite && paddr == ssrc_pkg::OFS_CTRL && !st_ff.armed)
        |=> $stable(st_ff.ctrl))
        else $error("control changed without arming");
    a_arm_one_access: assert property (@(posedge clk) disable iff (sys_rst)
        (st_ff.strap_done && setup && !(pwrite && paddr == ssrc_pkg::OFS_PROT_CMD))
        |=> !st_ff.armed)
        else $error("armed state survived an access");
    a_disabled_fixed: assert property (@(posedge clk) disable iff (sys_rst)
        !st_ff.ctrl.enable |=> (!modulation_enable && rate_code == 3'h0))
        else $error("modulation while disabled");
    a_rate_legal: assert property (@(posedge clk) disable iff (sys_rst)
        st_ff.strap_done |-> st_ff.ctrl.rate <= ssrc_pkg::RATE_MAX)
        else $error("prohibited rate code held");
    a_period_legal: assert property (@(posedge clk) disable iff (sys_rst)
        st_ff.strap_done |-> st_ff.ctrl.period != ssrc_pkg::PERIOD_BAD)
        else $error("prohibited period held");
    a_change_unlocks: assert property (@(posedge clk) disable iff (sys_rst)
        (st_ff.strap_done && $changed(st_ff.ctrl)) |-> ##2 unlocked)
        else $error("change did not unlock");
    a_write_main_sel: assert property (@(posedge clk) disable iff (sys_rst)
        (st_ff.strap_done && st_ff.clk_sel) |=> $stable(st_ff.ctrl))
        else $error("control changed with synth clock selected");
    a_read_direct: assert property (@(posedge clk) disable iff (sys_rst)
        (st_ff.strap_done && setup && !pwrite && paddr == ssrc_pkg::OFS_CTRL)
        |=> prdata[5:0] == {$past(st_ff.ctrl.period), $past(st_ff.ctrl.enable),
                            $past(st_ff.ctrl.rate)})
        else $error("control read mismatch");
    a_strap_period: assert property (@(posedge clk) disable iff (sys_rst)
        ($rose(st_ff.strap_done)) |-> st_ff.ctrl.period == ssrc_pkg::PERIOD_RST)
        else $error("reset period wrong");
endmodule : ssrc_top

// [sim/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    typedef struct packed {
        logic [7:0] wdata;
        logic [5:0] exp_ctrl;
    } ssrc_row_t;

    logic        clk;
    logic        sys_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        strap_pin_hi;
    logic        strap_pin_lo;
    logic        modulation_enable;
    logic [2:0]  rate_code;
    logic [1:0]  period_sel;
    logic        lock_pending;
    logic        sys_clk_from_synth;
    int          miscompares = 0;
    int          cmp_count   = 0;
    logic [31:0] rd;
    logic        er;
    ssrc_row_t   rows [9] = '{'{8'h08, 6'h08}, '{8'h19, 6'h19}, '{8'h2a, 6'h2a},
                              '{8'h1b, 6'h1b}, '{8'h1c, 6'h1c}, '{8'h1d, 6'h1d},
                              '{8'h1e, 6'h1d}, '{8'h3a, 6'h1d}, '{8'h15, 6'h15}};
    logic [5:0]  strap_exp [4] = '{6'h10, 6'h19, 6'h1b, 6'h1d};

    initial clk = 1'b0;
    always #50 clk = ~clk;

    ssrc_top dut_u (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .strap_pin_hi(strap_pin_hi), .strap_pin_lo(strap_pin_lo),
        .modulation_enable(modulation_enable), .rate_code(rate_code),
        .period_sel(period_sel), .lock_pending(lock_pending),
        .sys_clk_from_synth(sys_clk_from_synth)
    );

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
            miscompares++;
        end
    endtask : check

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) miscompares++;
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task prot_wr(input logic [7:0] d);
        apb(1'b1, ssrc_pkg::OFS_PROT_CMD, 32'(d));
        apb(1'b1, ssrc_pkg::OFS_CTRL, 32'(d));
        repeat (5) @(posedge clk);
    endtask : prot_wr

    task chk_out(input logic [5:0] c);
        repeat (3) @(posedge clk);
        apb(1'b0, ssrc_pkg::OFS_CTRL, 32'h0);
        check("ctrl", rd & 32'h3f, 32'(c));
        check("enable", 32'(modulation_enable), 32'(c[3]));
        check("rate", 32'(rate_code), c[3] ? 32'(c[2:0]) : 32'h0);
        check("period", 32'(period_sel), 32'(c[5:4]));
    endtask : chk_out

    task do_reset(input logic [1:0] s);
        strap_pin_hi <= s[1];
        strap_pin_lo <= s[0];
        sys_rst      <= 1'b1;
        repeat (6) @(posedge clk);
        sys_rst      <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : do_reset

    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    initial begin
        #(20000 * 100);
        miscompares++;
        finish_test();
    end

    initial begin
        sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; strap_pin_hi = 1'b0; strap_pin_lo = 1'b0;
        for (int s = 3; s >= 0; s--) begin
            do_reset(2'(s));
            chk_out(strap_exp[s]);
        end
        $display("test strap reset done");
        foreach (rows[i]) begin
            prot_wr(rows[i].wdata);
            check("ctrl err", 32'(er), 32'h0);
            chk_out(rows[i].exp_ctrl);
        end
        $display("test rate table done");
        apb(1'b1, ssrc_pkg::OFS_CTRL, 32'h08);
        check("unarmed err", 32'(er), 32'h1);
        apb(1'b1, ssrc_pkg::OFS_PROT_CMD, 32'h0);
        apb(1'b0, ssrc_pkg::OFS_STATUS, 32'h0);
        apb(1'b1, ssrc_pkg::OFS_CTRL, 32'h08);
        check("disarmed err", 32'(er), 32'h1);
        chk_out(6'h15);
        apb(1'b0, ssrc_pkg::OFS_PROT_CMD, 32'h0);
        check("cmd read", rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped err", 32'(er), 32'h1);
        check("unmapped read", rd, 32'h0);
        $display("test refusals done");
        repeat (ssrc_pkg::LOCK_CYCLES + 10) @(posedge clk);
        check("lock idle", 32'(lock_pending), 32'h0);
        prot_wr(8'h19);
        repeat (4) @(posedge clk);
        check("lock set", 32'(lock_pending), 32'h1);
        apb(1'b0, ssrc_pkg::OFS_STATUS, 32'h0);
        check("status set", rd, 32'h1);
        repeat (ssrc_pkg::LOCK_CYCLES + 5) @(posedge clk);
        check("lock clear", 32'(lock_pending), 32'h0);
        apb(1'b0, ssrc_pkg::OFS_STATUS, 32'h0);
        check("status clear", rd, 32'h0);
        apb(1'b1, ssrc_pkg::OFS_CLK_SEL, 32'h1);
        repeat (3) @(posedge clk);
        check("clk sel", 32'(sys_clk_from_synth), 32'h1);
        apb(1'b0, ssrc_pkg::OFS_CLK_SEL, 32'h0);
        check("clk sel read", rd, 32'h1);
        prot_wr(8'h08);
        check("sel store err", 32'(er), 32'h0);
        chk_out(6'h19);
        $display("test lock and clock select done");
        finish_test();
    end
endmodule : tb_top
